// ---- hdl/pit_periodic_timer.sv ----
/*
  Periodic interrupt timer: free-running counter with overflow flag,
  fast periodic interrupt from a counter tap, timer event flags and
  enables, accumulator control bits and the slow periodic interrupt
  driving the non-maskable line.
  Assumes the CPU drives the register port and cpuMode on clk; the
  crystal oscillator input is asynchronous and slower than clk / 2.
*/
`timescale 1ns/10ps

module pit_periodic_timer
   import pit_pkg::*;
#(
   parameter int PERIODIC_TAP_LOG2 = 15,
   parameter int SLOW_CHAIN_LOG2 = 18
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire pit_bus_req_t busReq,
   output logic [7:0] rdata,
   input wire pit_mode_t cpuMode,
   input wire logic specialMode,
   input wire logic stopRequest,
   input wire logic accumOverflowEvent,
   input wire logic accumEdgeEvent,
   input wire logic crystalOscillatorClock,
   output logic overflowIrq,
   output logic periodicIrq,
   output logic accumOverflowIrq,
   output logic accumEdgeIrq,
   output logic nonmaskableIrqLine,
   output logic stopEnter,
   output logic stopWake,
   output logic accumEnable,
   output logic accumMode,
   output logic accumEdgeControl,
   output logic fourthCaptureEnable,
   output logic fifthCompareEnable,
   output logic [1:0] timerPrescaleSelect,
   output logic [15:0] freeRunningCounter
);

   localparam int RTW = PERIODIC_TAP_LOG2 + 3;
   localparam int SW = SLOW_CHAIN_LOG2 + 1;
   // high part tap, clipped to the chain for short chains
   localparam int HIW = (PIT_SLOW_HIGH_BITS < SW) ? PIT_SLOW_HIGH_BITS : SW;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   logic wrEn2;
   logic wrFlags2;
   logic wrAccCtl;
   logic wrTrim;
   logic wrSlowCtl;
   assign wrEn2 = busReq.wr && (busReq.addr == PIT_OFS_IRQ_EN2);
   assign wrFlags2 = busReq.wr && (busReq.addr == PIT_OFS_FLAGS2);
   assign wrAccCtl = busReq.wr && (busReq.addr == PIT_OFS_ACC_CTL);
   assign wrTrim = busReq.wr && (busReq.addr == PIT_OFS_SLOW_TRIM);
   assign wrSlowCtl = busReq.wr && (busReq.addr == PIT_OFS_SLOW_CTL);

   // ----------------------------------------
   // enables and timer prescale select
   // ----------------------------------------
   logic [7:4] irqEnable;
   logic [6:0] cycleCount;
   logic timerPrescWritten;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         irqEnable <= PIT_RST_ZERO[7:4];
      end else if (wrEn2) begin
         irqEnable <= busReq.wdata[7:4];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cycleCount <= 7'h00;
      end else if (cycleCount != PIT_PRESC_WINDOW) begin
         cycleCount <= cycleCount + 7'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         timerPrescaleSelect <= PIT_RST_SEL;
         timerPrescWritten <= 1'b0;
      end else if (wrEn2 && (specialMode
            || (!timerPrescWritten && cycleCount != PIT_PRESC_WINDOW))) begin
         timerPrescaleSelect <= busReq.wdata[1:0];
         timerPrescWritten <= 1'b1;
      end
   end

   // ----------------------------------------
   // free-running counter
   // ----------------------------------------
   logic [3:0] tmrPresc;
   logic [3:0] tmrTerm;
   logic tmrTick;
   logic overflowEvent;

   always_comb begin
      unique case (timerPrescaleSelect)
         2'h0: tmrTerm = PIT_TMR_TERM_0;
         2'h1: tmrTerm = PIT_TMR_TERM_1;
         2'h2: tmrTerm = PIT_TMR_TERM_2;
         2'h3: tmrTerm = PIT_TMR_TERM_3;
      endcase
   end

   assign tmrTick = (tmrPresc >= tmrTerm);
   assign overflowEvent = tmrTick && (freeRunningCounter == 16'hFFFF);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tmrPresc <= 4'h0;
         freeRunningCounter <= 16'h0000;
      end else if (tmrTick) begin
         tmrPresc <= 4'h0;
         freeRunningCounter <= freeRunningCounter + 16'h0001;
      end else begin
         tmrPresc <= tmrPresc + 4'h1;
      end
   end

   // ----------------------------------------
   // fast periodic source
   // ----------------------------------------
   logic [RTW-1:0] periodicDiv;
   logic [RTW-1:0] tapMask;
   logic [1:0] periodicRateSelect;
   logic periodicEvent;

   // tap ones cover 2^15 times the selected divisor
   assign tapMask = {RTW{1'b1}} >> (2'h3 - periodicRateSelect);
   assign periodicEvent = ((periodicDiv & tapMask) == tapMask);

   // free divider, independent of prescale and flag service
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         periodicDiv <= '0;
      end else begin
         periodicDiv <= periodicDiv + 1'b1;
      end
   end

   // ----------------------------------------
   // accumulator and rate control
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         accumEnable <= 1'b0;
         accumMode <= 1'b0;
         accumEdgeControl <= 1'b0;
         fourthCaptureEnable <= 1'b0;
         fifthCompareEnable <= 1'b1;
         periodicRateSelect <= PIT_RST_SEL;
      end else if (wrAccCtl) begin
         accumEnable <= busReq.wdata[PIT_BIT_ACC_EN];
         accumMode <= busReq.wdata[PIT_BIT_ACC_MODE];
         accumEdgeControl <= busReq.wdata[PIT_BIT_ACC_ACCUM_EDGE_CONTROL];
         fourthCaptureEnable <= busReq.wdata[PIT_BIT_CAP_SEL];
         fifthCompareEnable <= !busReq.wdata[PIT_BIT_CAP_SEL];
         periodicRateSelect <= busReq.wdata[1:0];
      end
   end

   // ----------------------------------------
   // timer event flags and interrupts
   // ----------------------------------------
   logic [7:4] eventFlag;
   logic [7:4] eventSet;
   logic [7:4] irqLine;

   assign eventSet = {overflowEvent, periodicEvent, accumOverflowEvent, accumEdgeEvent};

   for (genvar i = 4; i < 8; i++) begin : gFlag
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            eventFlag[i] <= 1'b0;
         end else if (eventSet[i]) begin
            eventFlag[i] <= 1'b1;
         end else if (wrFlags2 && busReq.wdata[i]) begin
            eventFlag[i] <= 1'b0;
         end
      end

      always_ff @(posedge clk) begin
         if (!rst_b) begin
            irqLine[i] <= 1'b0;
         end else begin
            irqLine[i] <= eventFlag[i] && irqEnable[i];
         end
      end
   end

   assign overflowIrq = irqLine[PIT_BIT_OVF];
   assign periodicIrq = irqLine[PIT_BIT_PER];
   assign accumOverflowIrq = irqLine[PIT_BIT_ACC_OVF];
   assign accumEdgeIrq = irqLine[PIT_BIT_ACC_EDGE];

   // ----------------------------------------
   // oscillator synchroniser
   // ----------------------------------------
   logic oscMeta;
   logic oscSync;
   logic oscPrev;
   logic oscTick;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         oscMeta <= 1'b0;
         oscSync <= 1'b0;
         oscPrev <= 1'b0;
      end else begin
         oscMeta <= crystalOscillatorClock;
         oscSync <= oscMeta;
         oscPrev <= oscSync;
      end
   end

   assign oscTick = oscSync && !oscPrev;

   // ----------------------------------------
   // slow periodic control
   // ----------------------------------------
   logic [3:0] slowTrimValue;
   logic [1:0] slowPrescaleSelect;
   logic slowPrescWritten;
   logic slowIrqEnable;
   logic slowPrescAccept;
   logic slowReload;

   assign slowPrescAccept = wrSlowCtl && (specialMode || !slowPrescWritten);
   assign slowReload = slowPrescAccept || (wrTrim && specialMode);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         slowTrimValue <= PIT_RST_TRIM;
      end else if (wrTrim) begin
         slowTrimValue <= busReq.wdata[7:4];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         slowIrqEnable <= 1'b0;
      end else if (wrSlowCtl) begin
         slowIrqEnable <= busReq.wdata[PIT_BIT_SLOW_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         slowPrescaleSelect <= PIT_RST_SEL;
         slowPrescWritten <= 1'b0;
      end else if (slowPrescAccept) begin
         slowPrescaleSelect <= busReq.wdata[3:2];
         slowPrescWritten <= 1'b1;
      end
   end

   // ----------------------------------------
   // slow down-counter chain
   // ----------------------------------------
   logic [3:0] slowPresc;
   logic [3:0] slowTerm;
   logic [SW-1:0] slowCount;
   logic [SW-1:0] slowLoad;
   logic slowStep;
   logic [2:0] slowFlag;
   logic [2:0] slowSet;

   always_comb begin
      unique case (slowPrescaleSelect)
         2'h0: slowTerm = PIT_SLOW_TERM_0;
         2'h1: slowTerm = PIT_SLOW_TERM_1;
         2'h2: slowTerm = PIT_SLOW_TERM_2;
         2'h3: slowTerm = PIT_SLOW_TERM_3;
      endcase
   end

   // nominal chain length plus signed trim
   assign slowLoad = {1'b1, {SLOW_CHAIN_LOG2{1'b0}}}
      + {{(SW-4){slowTrimValue[3]}}, slowTrimValue};
   assign slowStep = oscTick && (slowPresc >= slowTerm);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         slowPresc <= 4'h0;
         slowCount <= {1'b1, {SLOW_CHAIN_LOG2{1'b0}}} - {{(SW-1){1'b0}}, 1'b1};
      end else if (slowReload) begin
         slowPresc <= 4'h0;
         slowCount <= slowLoad;
      end else if (slowStep) begin
         slowPresc <= 4'h0;
         slowCount <= (slowCount == '0) ? slowLoad : slowCount - 1'b1;
      end else if (oscTick) begin
         slowPresc <= slowPresc + 4'h1;
      end
   end

   assign slowSet[2] = slowStep && !slowReload && (slowCount == '0);
   assign slowSet[1] = slowStep && !slowReload
      && (slowCount[HIW-1:0] == '0);
   assign slowSet[0] = slowStep && !slowReload
      && (slowCount[PIT_SLOW_LOW_BITS-1:0] == '0);

   for (genvar j = 0; j < 3; j++) begin : gSlowFlag
      localparam int POS = (j == 2) ? PIT_BIT_SLOW_FLAG
         : (j == 1) ? PIT_BIT_SLOW_HI : PIT_BIT_SLOW_LO;
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            slowFlag[j] <= 1'b0;
         end else if (slowSet[j]) begin
            slowFlag[j] <= 1'b1;
         end else if (wrSlowCtl && busReq.wdata[POS]) begin
            slowFlag[j] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // non-maskable line and stop control
   // ----------------------------------------
   logic slowRequest;

   always_comb begin
      unique case (cpuMode)
         PIT_MODE_RUN: slowRequest = slowFlag[2] && slowIrqEnable;
         PIT_MODE_WAIT: slowRequest = slowFlag[2];
         PIT_MODE_STOP: slowRequest = slowFlag[2];
         default: slowRequest = slowFlag[2];
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         nonmaskableIrqLine <= 1'b0;
         stopWake <= 1'b0;
         stopEnter <= 1'b0;
      end else begin
         nonmaskableIrqLine <= slowRequest;
         stopWake <= slowRequest && (cpuMode == PIT_MODE_STOP);
         stopEnter <= stopRequest && !slowFlag[2];
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = PIT_RST_ZERO;
      if (busReq.rd) begin
         unique case (busReq.addr)
            PIT_OFS_COUNT_HI: next_rdata = freeRunningCounter[15:8];
            PIT_OFS_COUNT_LO: next_rdata = freeRunningCounter[7:0];
            PIT_OFS_IRQ_EN2: next_rdata = {irqEnable, 2'h0, timerPrescaleSelect};
            PIT_OFS_FLAGS2: next_rdata = {eventFlag, 4'h0};
            PIT_OFS_ACC_CTL: next_rdata = {1'b0, accumEnable, accumMode,
               accumEdgeControl, 1'b0, fourthCaptureEnable, periodicRateSelect};
            PIT_OFS_SLOW_TRIM: next_rdata = {slowTrimValue, 4'h0};
            PIT_OFS_SLOW_CTL: next_rdata = {slowFlag[2], slowIrqEnable, 2'h0,
               slowPrescaleSelect, slowFlag[1], slowFlag[0]};
            default: next_rdata = PIT_RST_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata <= PIT_RST_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence sClearFlag6;
      wrFlags2 && busReq.wdata[PIT_BIT_PER] && !periodicEvent;
   endsequence

   sequence sSlowSecondWrite;
      slowPrescWritten && !specialMode && wrSlowCtl;
   endsequence

   AST_OVF_IRQ: assert property (eventFlag[7] && irqEnable[7] |=> overflowIrq)
      else $error("overflow interrupt missing");
   AST_PER_MASKED: assert property (!irqEnable[6] |=> !periodicIrq)
      else $error("periodic interrupt while disabled");
   AST_UPPER_MASK: assert property (!(eventFlag[5] && irqEnable[5]) |=> !accumOverflowIrq)
      else $error("accumulator interrupt without mask");
   AST_W1C: assert property (sClearFlag6 |=> !eventFlag[PIT_BIT_PER])
      else $error("periodic flag not cleared");
   AST_ZERO_KEEP: assert property (eventFlag[7] && wrFlags2 && !busReq.wdata[7]
      |=> eventFlag[7])
      else $error("flag lost on zero write");
   AST_OVF_SET: assert property (tmrTick && freeRunningCounter == 16'hFFFF
      |=> eventFlag[7] && freeRunningCounter == 16'h0000)
      else $error("overflow flag not set on wrap");
   AST_PER_SET: assert property (periodicEvent |=> eventFlag[6] ##1 !periodicEvent)
      else $error("periodic flag not set");
   AST_RD_ZERO: assert property (busReq.rd && busReq.addr == PIT_OFS_FLAGS2
      |=> rdata[3:0] == 4'h0)
      else $error("unimplemented flag bits read nonzero");
   AST_RUN_GATE: assert property (cpuMode == PIT_MODE_RUN && !slowIrqEnable
      |=> !nonmaskableIrqLine)
      else $error("slow request passed while disabled");
   AST_SLEEP_PASS: assert property (slowFlag[2] && cpuMode != PIT_MODE_RUN
      |=> nonmaskableIrqLine)
      else $error("slow request blocked in wait or stop");
   AST_NO_STOP: assert property (stopRequest && slowFlag[2] |=> !stopEnter)
      else $error("stop entered with slow flag set");
   AST_ONCE: assert property (sSlowSecondWrite |=> $stable(slowPrescaleSelect))
      else $error("slow prescale rewritten");

endmodule

// ---- hdl/pit_pkg.sv ----
/*
  Shared constants and types for the periodic interrupt timer: register
  offsets, field positions, reset values, timing counts, CPU mode codes
  and the register bus carrier.
  Assumes an 8-bit register bus and a single 10 MHz timer clock.
*/
package pit_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] PIT_OFS_COUNT_HI = 8'h0E;
   localparam logic [7:0] PIT_OFS_COUNT_LO = 8'h0F;
   localparam logic [7:0] PIT_OFS_IRQ_EN2 = 8'h24;
   localparam logic [7:0] PIT_OFS_FLAGS2 = 8'h25;
   localparam logic [7:0] PIT_OFS_ACC_CTL = 8'h26;
   localparam logic [7:0] PIT_OFS_SLOW_TRIM = 8'h33;
   localparam logic [7:0] PIT_OFS_SLOW_CTL = 8'h34;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int PIT_BIT_OVF = 7;
   localparam int PIT_BIT_PER = 6;
   localparam int PIT_BIT_ACC_OVF = 5;
   localparam int PIT_BIT_ACC_EDGE = 4;
   localparam int PIT_BIT_ACC_EN = 6;
   localparam int PIT_BIT_ACC_MODE = 5;
   localparam int PIT_BIT_ACC_ACCUM_EDGE_CONTROL = 4;
   localparam int PIT_BIT_CAP_SEL = 2;
   localparam int PIT_BIT_SLOW_FLAG = 7;
   localparam int PIT_BIT_SLOW_EN = 6;
   localparam int PIT_BIT_SLOW_HI = 1;
   localparam int PIT_BIT_SLOW_LO = 0;
   localparam int PIT_SLOW_LOW_BITS = 4;
   localparam int PIT_SLOW_HIGH_BITS = 12;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] PIT_RST_ZERO = 8'h00;
   localparam logic [3:0] PIT_RST_TRIM = 4'hF;
   localparam logic [1:0] PIT_RST_SEL = 2'h0;

   // ----------------------------------------
   // timing counts in timer clocks
   // ----------------------------------------
   localparam logic [6:0] PIT_PRESC_WINDOW = 7'h40;
   localparam logic [3:0] PIT_TMR_TERM_0 = 4'h0;
   localparam logic [3:0] PIT_TMR_TERM_1 = 4'h3;
   localparam logic [3:0] PIT_TMR_TERM_2 = 4'h7;
   localparam logic [3:0] PIT_TMR_TERM_3 = 4'hF;
   // slow prescaler terminal, oscillator edges
   localparam logic [3:0] PIT_SLOW_TERM_0 = 4'h7;
   localparam logic [3:0] PIT_SLOW_TERM_1 = 4'h3;
   localparam logic [3:0] PIT_SLOW_TERM_2 = 4'h1;
   localparam logic [3:0] PIT_SLOW_TERM_3 = 4'hF;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      PIT_MODE_RUN = 3'b001,
      PIT_MODE_WAIT = 3'b010,
      PIT_MODE_STOP = 3'b100
   } pit_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pit_bus_req_t;

endpackage

// ---- tb/pit_cpu_model.sv ----
/*
  CPU side model: register bus master and flag service routines.
  Assumes the timer samples busReq on the rising edge of clk and
  returns read data in the cycle after the read strobe.
*/
`timescale 1ns/10ps

module pit_cpu_model
   import pit_pkg::*;
(
   input wire logic clk,
   output pit_bus_req_t busReq,
   input wire logic [7:0] rdata
);
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   initial begin
      busReq = '0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      busReq <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask

   // ----------------------------------------
   // flag service
   // ----------------------------------------
   task automatic clrFlags(input logic [7:0] m);
      wr(PIT_OFS_FLAGS2, m);
   endtask

   task automatic clrSlow();
      wr(PIT_OFS_SLOW_CTL, 8'h83);
   endtask
endmodule

// ---- tb/tb_periodic_interrupt_timer.sv ----
/*
  Self-checking bench for the periodic interrupt timer.
  Assumes shortened counts: periodic tap 2^4, slow chain 2^6.
*/
`timescale 1ns/10ps

module tb_periodic_interrupt_timer
   import pit_pkg::*;
();
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk, rst_b, specialMode, stopRequest, accumOverflowEvent, accumEdgeEvent;
   logic crystalOscillatorClock, overflowIrq, periodicIrq, accumOverflowIrq;
   logic accumEdgeIrq, nonmaskableIrqLine, stopEnter, stopWake, accumEnable, accumMode;
   logic accumEdgeControl, fourthCaptureEnable, fifthCompareEnable;
   logic [1:0] timerPrescaleSelect;
   logic [15:0] freeRunningCounter;
   logic [7:0] rdata, d;
   pit_mode_t cpuMode;
   pit_bus_req_t busReq;
   int mismatches, nTests, cyc, t0;
   wire [2:0] irqs = {nonmaskableIrqLine, overflowIrq, periodicIrq};
   // accumulator control rows: write, read back, {en, mode, edge, cap, cmp}
   logic [20:0] rows [5] = '{{8'hFF, 8'h77, 5'h1E}, {8'h08, 8'h00, 5'h01},
      {8'h44, 8'h44, 5'h12}, {8'h20, 8'h20, 5'h09}, {8'h10, 8'h10, 5'h05}};

   pit_periodic_timer #(.PERIODIC_TAP_LOG2(4), .SLOW_CHAIN_LOG2(6)) DUT (.clk, .rst_b,
      .busReq, .rdata, .cpuMode, .specialMode, .stopRequest, .accumOverflowEvent,
      .accumEdgeEvent, .crystalOscillatorClock, .overflowIrq, .periodicIrq,
      .accumOverflowIrq, .accumEdgeIrq, .nonmaskableIrqLine, .stopEnter, .stopWake,
      .accumEnable, .accumMode, .accumEdgeControl, .fourthCaptureEnable,
      .fifthCompareEnable, .timerPrescaleSelect, .freeRunningCounter);

   pit_cpu_model cpu (.clk, .busReq, .rdata);

   // ----------------------------------------
   // clocks and timeout
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   initial begin
      crystalOscillatorClock = 1'b0;
      forever #487 crystalOscillatorClock = ~crystalOscillatorClock;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         mismatches++;
         end_sim();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      nTests++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chkb(input logic seen, input logic exp);
      chk({7'h00, seen}, {7'h00, exp});
   endtask

   task automatic waitIrq(input int s, input logic v, input int lim);
      int k;
      k = 0;
      while (irqs[s] !== v && k < lim) begin
         @(negedge clk);
         k++;
      end
      chkb(irqs[s], v);
   endtask

   task automatic settle();
      repeat (2) @(negedge clk);
   endtask

   task automatic stopPulse();
      @(posedge clk);
      stopRequest <= 1'b1;
      @(posedge clk);
      stopRequest <= 1'b0;
      @(negedge clk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", nTests, mismatches);
      if (mismatches == 0 && nTests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      specialMode = 1'b0;
      stopRequest = 1'b0;
      accumOverflowEvent = 1'b0;
      accumEdgeEvent = 1'b0;
      cpuMode = PIT_MODE_RUN;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h0C);
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h03);
      cpu.rd(PIT_OFS_FLAGS2, d);
      chk(d, 8'h00);
      cpu.rd(PIT_OFS_IRQ_EN2, d);
      chk(d, 8'h00);
      cpu.rd(PIT_OFS_SLOW_TRIM, d);
      chk(d, 8'hF0);
      cpu.rd(8'h40, d);
      chk(d, 8'h00);
      chkb(fifthCompareEnable, 1'b1);
      cpu.wr(PIT_OFS_FLAGS2, 8'h0F);
      cpu.rd(PIT_OFS_FLAGS2, d);
      chk(d & 8'h0F, 8'h00);
      for (int i = 0; i < 5; i++) begin
         cpu.wr(PIT_OFS_ACC_CTL, rows[i][20:13]);
         cpu.rd(PIT_OFS_ACC_CTL, d);
         chk(d, rows[i][12:5]);
         chk({3'h0, accumEnable, accumMode, accumEdgeControl, fourthCaptureEnable,
            fifthCompareEnable}, {3'h0, rows[i][4:0]});
      end
      $display("test registers done");
      @(posedge clk);
      accumOverflowEvent <= 1'b1;
      accumEdgeEvent <= 1'b1;
      @(posedge clk);
      accumOverflowEvent <= 1'b0;
      accumEdgeEvent <= 1'b0;
      settle();
      chk({6'h00, accumOverflowIrq, accumEdgeIrq}, 8'h00);
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h20);
      settle();
      chk({6'h00, accumOverflowIrq, accumEdgeIrq}, 8'h02);
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h30);
      settle();
      chk({6'h00, accumOverflowIrq, accumEdgeIrq}, 8'h03);
      cpu.clrFlags(8'h00);
      cpu.rd(PIT_OFS_FLAGS2, d);
      chk(d & 8'h30, 8'h30);
      cpu.clrFlags(8'h20);
      cpu.rd(PIT_OFS_FLAGS2, d);
      chk(d & 8'h30, 8'h10);
      settle();
      chkb(accumOverflowIrq, 1'b0);
      $display("test masks done");
      @(posedge clk);
      specialMode <= 1'b1;
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h43);
      specialMode <= 1'b0;
      for (int r = 0; r < 4; r++) begin
         cpu.wr(PIT_OFS_ACC_CTL, 8'(r));
         for (int n = 0; n < 3; n++) begin
            waitIrq(0, 1'b1, 300);
            if (n == 2) begin
               chk(8'(cyc - t0), 8'(16 << r));
            end
            t0 = cyc;
            cpu.clrFlags(8'h40);
            waitIrq(0, 1'b0, 50);
         end
      end
      chk({6'h00, timerPrescaleSelect}, 8'h03);
      @(posedge clk);
      specialMode <= 1'b1;
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h00);
      specialMode <= 1'b0;
      repeat (150) @(negedge clk);
      chkb(periodicIrq, 1'b0);
      cpu.rd(PIT_OFS_FLAGS2, d);
      chk(d & 8'h40, 8'h40);
      $display("test periodic done");
      cpu.wr(PIT_OFS_SLOW_CTL, 8'h40);
      waitIrq(2, 1'b1, 8000);
      cpu.rd(PIT_OFS_SLOW_CTL, d);
      chk(d & 8'hC3, 8'hC3);
      cpu.wr(PIT_OFS_SLOW_CTL, 8'h0C);
      settle();
      chkb(nonmaskableIrqLine, 1'b0);
      cpu.rd(PIT_OFS_SLOW_CTL, d);
      chk(d & 8'hCC, 8'h80);
      @(posedge clk);
      cpuMode <= PIT_MODE_WAIT;
      settle();
      chkb(nonmaskableIrqLine, 1'b1);
      stopPulse();
      chkb(stopEnter, 1'b0);
      @(posedge clk);
      cpuMode <= PIT_MODE_STOP;
      settle();
      chkb(stopWake, 1'b1);
      @(posedge clk);
      cpuMode <= PIT_MODE_RUN;
      cpu.clrSlow();
      cpu.rd(PIT_OFS_SLOW_CTL, d);
      chk(d & 8'h83, 8'h00);
      stopPulse();
      chkb(stopEnter, 1'b1);
      $display("test slow done");
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h80);
      waitIrq(1, 1'b1, 70000);
      cpu.rd(PIT_OFS_COUNT_HI, d);
      chk(d, 8'h00);
      cpu.wr(PIT_OFS_IRQ_EN2, 8'h00);
      settle();
      chkb(overflowIrq, 1'b0);
      cpu.rd(PIT_OFS_FLAGS2, d);
      chk(d & 8'h80, 8'h80);
      $display("test overflow done");
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      settle();
      chk(freeRunningCounter[15:8], 8'h00);
      cpu.rd(PIT_OFS_ACC_CTL, d);
      chk(d, 8'h00);
      cpu.rd(PIT_OFS_FLAGS2, d);
      chk(d, 8'h00);
      $display("test reset done");
      end_sim();
   end
endmodule
